// ### dif_pkg.sv
/*
 Shared constants and types for the drive input-function control block.
 Assumes one 25 MHz control clock and an active-low asynchronous reset.
*/
package dif_pkg;
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned NUM_INPUTS    = 6;
   // resume delay is given in milliseconds, converted to cycles below
   localparam int unsigned DELAY_MS_W    = 16;
   localparam int unsigned MS_PER_S      = 1000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
   localparam int unsigned CNT_W         = 16;
   localparam logic [CNT_W-1:0] CYC_PER_MS_C = CNT_W'(CYC_PER_MS);
   localparam int unsigned ERR_W         = 8;
   localparam logic [ERR_W-1:0] ERR_NONE = 8'h00;
   localparam logic [ERR_W-1:0] ERR_EXT  = 8'h0c;
   localparam logic [1:0]  SYNC_RST      = 2'h0;
   localparam logic [DELAY_MS_W-1:0] MS_RST = 16'h0000;
   localparam logic [CNT_W-1:0]      CNT_RST = 16'h0000;

   // input bit positions inside the synchronised terminal vector
   localparam int unsigned IN_FWD   = 0;
   localparam int unsigned IN_REV   = 1;
   localparam int unsigned IN_SET   = 2;
   localparam int unsigned IN_COAST = 3;
   localparam int unsigned IN_FAULT = 4;
   localparam int unsigned IN_CLEAR = 5;

   typedef enum logic [2:0] {
      ST_STOP,
      ST_RUN,
      ST_COAST,
      ST_WAIT,
      ST_TRIP,
      ST_HOLD
   } dif_state_t;
endpackage : dif_pkg

// ### dif_sync_if.sv
/*
 Carries raw terminal levels in and synchronised levels plus edges out.
 Assumes both ends run on the same control clock.
*/
`timescale 1ns/1ps
interface dif_sync_if;
   logic [5:0] raw;
   logic [5:0] level;
   logic [5:0] rise;
   logic [5:0] fall;
   modport src (input raw, output level, output rise, output fall);
   modport dst (output raw, input level, input rise, input fall);
endinterface : dif_sync_if

// ### dif_sync.sv
/*
 Two-flop synchronisers for every terminal input, followed by edge detect.
 Assumes terminal levels are asynchronous to CLK.
*/
`timescale 1ns/1ps
module dif_sync (
   input  wire logic CLK,
   input  wire logic ARST_N,
   dif_sync_if.src   sio
);
   import dif_pkg::*;

   typedef struct packed {
      logic [NUM_INPUTS-1:0] meta;
      logic [NUM_INPUTS-1:0] sync;
      logic [NUM_INPUTS-1:0] prev;
   } dif_sync_st_t;

   dif_sync_st_t st;
   dif_sync_st_t next_st;

   always_comb begin
      next_st      = st;
      next_st.meta = sio.raw;
      next_st.sync = st.meta;
      next_st.prev = st.sync;
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // edges only from stable flops; meta feeds sync alone
   assign sio.level = st.sync;
   assign sio.rise  = st.sync & ~st.prev;
   assign sio.fall  = ~st.sync & st.prev;
endmodule : dif_sync

// ### dif_ctrl.sv
/*
 Drive input-function control: motor set select, coast stop with resume
 delay and resume mode, external fault trip with alarm and clear.
 Assumes terminal inputs are asynchronous; settings are quasi-static.
*/
// How it works
// - second parameter set in use while select input is on and applied.
// - select changes take effect only when drive is stopped.
// - select off and applied returns to main parameter set.
// - coast stop disables output immediately, no ramp down.
// - coast release resumes output only if run command still active.
// - resume mode chooses restart from zero or from measured speed.
// - wait the resume delay before restart; zero means no wait.
// - coast input polarity selectable as normally closed.
// - fault rising edge trips, stops output, reports external error code.
// - fault falling edge makes no event; history kept until reset.
// - trip stays latched; only reset clears it, entering stop unless run still active.
// - trip in run lets motor coast and raises alarm at once.
// - reset clears alarm and error; restart if run still active and coast is off.
// - start guard input is unused; reset restarts whenever run still active and coast is off.
// - forward and reverse together count as stop.
// - clear input on then off performs reset cancelling trip.
`timescale 1ns/1ps
module dif_ctrl (
   input  wire logic                          CLK,
   input  wire logic                          ARST_N,
   input  wire logic                          FORWARD_RUN_INPUT,
   input  wire logic                          REVERSE_RUN_INPUT,
   input  wire logic                          SECOND_MOTOR_SELECT,
   input  wire logic                          COAST_STOP,
   input  wire logic                          EXTERNAL_FAULT,
   input  wire logic                          FAULT_CLEAR_INPUT,
   input  wire logic                          KEYPAD_RESET,
   input  wire logic                          COAST_ACTIVE_LOW,
   input  wire logic                          COAST_RESUME_MODE,
   input  wire logic [dif_pkg::DELAY_MS_W-1:0] RESUME_DELAY_TIME,
   input  wire logic                          UNATTENDED_START_GUARD,
   output logic                               OUTPUT_ENABLE,
   output logic                               RUN_REVERSE,
   output logic                               START_FROM_SPEED,
   output logic                               SECOND_SET_ACTIVE,
   output logic                               ALARM,
   output logic [dif_pkg::ERR_W-1:0]          ERROR_CODE,
   output logic                               TRIP_HISTORY,
   output logic [2:0]                         STATE
);
   import dif_pkg::*;

   typedef struct packed {
      dif_state_t            state;
      logic                  out_en;
      logic                  rev;
      logic                  from_speed;
      logic                  second_set;
      logic                  alarm;
      logic [ERR_W-1:0]      err;
      logic                  history;
      logic [DELAY_MS_W-1:0] ms_left;
      logic [CNT_W-1:0]      cyc;
   } dif_ctrl_st_t;

   dif_ctrl_st_t st;
   dif_ctrl_st_t next_st;

   dif_sync_if sio ();

   // keypad is a panel button, synchronised with the terminals
   logic kp_meta;
   logic kp_sync;
   logic kp_prev;

   assign sio.raw = {FAULT_CLEAR_INPUT, EXTERNAL_FAULT, COAST_STOP,
                     SECOND_MOTOR_SELECT, REVERSE_RUN_INPUT, FORWARD_RUN_INPUT};

   dif_sync u_sync (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .sio    (sio)
   );

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         kp_meta <= 1'b0;
         kp_sync <= 1'b0;
         kp_prev <= 1'b0;
      end else begin
         kp_meta <= KEYPAD_RESET;
         kp_sync <= kp_meta;
         kp_prev <= kp_sync;
      end
   end

   logic fwd;
   logic rev;
   logic run_cmd;
   logic run_rise;
   logic coast;
   logic reset_op;
   logic kp_rise;

   always_comb begin
      fwd      = sio.level[IN_FWD];
      rev      = sio.level[IN_REV];
      run_cmd  = (fwd ^ rev);
      // new run edge: either direction rises while the other is off
      run_rise = (sio.rise[IN_FWD] & ~rev) | (sio.rise[IN_REV] & ~fwd);
      coast    = sio.level[IN_COAST] ^ COAST_ACTIVE_LOW;
      kp_rise  = kp_sync & ~kp_prev;
      // reset acts on release of the clear terminal
      reset_op = sio.fall[IN_CLEAR] | kp_rise;
   end

   function automatic dif_ctrl_st_t start_delay(input dif_ctrl_st_t s,
                                                input logic [DELAY_MS_W-1:0] ms);
      dif_ctrl_st_t r;
      r         = s;
      r.out_en  = 1'b0;
      r.ms_left = ms;
      r.cyc     = CNT_RST;
      r.state   = (ms == MS_RST) ? ST_RUN : ST_WAIT;
      r.out_en  = (ms == MS_RST);
      return r;
   endfunction : start_delay

   always_comb begin
      next_st = st;
      case (st.state)
         ST_STOP: begin
            next_st.out_en     = 1'b0;
            next_st.from_speed = 1'b0;
            // parameter set latched only while stopped
            next_st.second_set = sio.level[IN_SET];
            if (run_cmd && !coast) begin
               next_st.state  = ST_RUN;
               next_st.out_en = 1'b1;
               next_st.rev    = rev;
            end else if (run_cmd && coast) begin
               next_st.state = ST_COAST;
               next_st.rev   = rev;
            end
         end
         ST_RUN: begin
            // second_set frozen while running
            next_st.out_en = 1'b1;
            if (!run_cmd) begin
               next_st.state  = ST_STOP;
               next_st.out_en = 1'b0;
            end else if (coast) begin
               next_st.state  = ST_COAST;
               next_st.out_en = 1'b0;
            end else begin
               next_st.rev = rev;
            end
         end
         ST_COAST: begin
            next_st.out_en = 1'b0;
            if (!run_cmd) begin
               next_st.state = ST_STOP;
            end else if (!coast) begin
               next_st            = start_delay(st, RESUME_DELAY_TIME);
               next_st.from_speed = COAST_RESUME_MODE;
               next_st.rev        = rev;
            end
         end
         ST_WAIT: begin
            next_st.out_en = 1'b0;
            if (!run_cmd) begin
               next_st.state = ST_STOP;
            end else if (coast) begin
               next_st.state = ST_COAST;
            end else if (st.cyc == CYC_PER_MS_C - 16'h0001) begin
               next_st.cyc     = CNT_RST;
               next_st.ms_left = st.ms_left - 16'h0001;
               if (st.ms_left == 16'h0001) begin
                  next_st.state  = ST_RUN;
                  next_st.out_en = 1'b1;
               end
            end else begin
               next_st.cyc = st.cyc + 16'h0001;
            end
         end
         ST_TRIP: begin
            next_st.out_en = 1'b0;
            if (reset_op) begin
               next_st.alarm = 1'b0;
               next_st.err   = ERR_NONE;
               next_st.history = 1'b0;
               // guard not consulted; restart decided by run and coast levels alone
               next_st.state = (run_cmd && !coast) ? ST_RUN : ST_STOP;
               next_st.out_en = run_cmd && !coast;
               if (run_cmd && coast) begin
                  next_st.state = ST_COAST;
               end
            end
         end
         ST_HOLD: begin
            // guard: no transition enters this state; would leave on run edge, reset or run off
            next_st.out_en = 1'b0;
            if (run_rise || reset_op || !run_cmd) begin
               next_st.state = ST_STOP;
            end
         end
         default: begin
            next_st.state  = ST_STOP;
            next_st.out_en = 1'b0;
         end
      endcase
      // fault rising edge beats everything else; falling edge ignored
      if (sio.rise[IN_FAULT]) begin
         next_st.state   = ST_TRIP;
         next_st.out_en  = 1'b0;
         next_st.alarm   = 1'b1;
         next_st.err     = ERR_EXT;
         next_st.history = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st       <= '0;
         st.state <= ST_STOP;
         st.err   <= ERR_NONE;
      end else begin
         st <= next_st;
      end
   end

   // guard input is not used by any logic; no state depends on it
   logic guard_unused;
   assign guard_unused = UNATTENDED_START_GUARD;

   assign OUTPUT_ENABLE     = st.out_en;
   assign RUN_REVERSE       = st.rev;
   assign START_FROM_SPEED  = st.from_speed;
   assign SECOND_SET_ACTIVE = st.second_set;
   assign ALARM             = st.alarm;
   assign ERROR_CODE        = st.err;
   assign TRIP_HISTORY      = st.history;
   assign STATE             = st.state;
endmodule : dif_ctrl

// ### dif_ctrl_asserts.sv
/*
 Port-level assertions for the input-function control block.
 Assumes the block's timing: pins are acted on three edges after they change.
*/
`timescale 1ns/1ps
module dif_ctrl_asserts (
   input wire logic                          CLK,
   input wire logic                          ARST_N,
   input wire logic                          FORWARD_RUN_INPUT,
   input wire logic                          REVERSE_RUN_INPUT,
   input wire logic                          SECOND_MOTOR_SELECT,
   input wire logic                          COAST_STOP,
   input wire logic                          EXTERNAL_FAULT,
   input wire logic                          FAULT_CLEAR_INPUT,
   input wire logic                          KEYPAD_RESET,
   input wire logic                          COAST_ACTIVE_LOW,
   input wire logic                          OUTPUT_ENABLE,
   input wire logic                          SECOND_SET_ACTIVE,
   input wire logic                          ALARM,
   input wire logic                          TRIP_HISTORY,
   input wire logic [dif_pkg::ERR_W-1:0]     ERROR_CODE,
   input wire logic [2:0]                    STATE
);
   import dif_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // six quiet samples cover the sync pipeline with margin
   sequence s_no_clear;
      (!FAULT_CLEAR_INPUT && !KEYPAD_RESET) [*6];
   endsequence
   sequence s_trip_seen;
      ALARM && STATE == 3'h4;
   endsequence
   AST_TRIP: assert property ($rose(EXTERNAL_FAULT) |-> ##[2:4] s_trip_seen)
      else $error("fault edge did not trip");
   AST_ALARM_ERR: assert property (ALARM |-> ERROR_CODE == ERR_EXT && !OUTPUT_ENABLE && TRIP_HISTORY)
      else $error("alarm without code or with output");
   AST_LATCH: assert property (s_no_clear ##0 ALARM |=> ALARM)
      else $error("trip dropped without reset");
   AST_ERR_NONE: assert property (!ALARM |-> ERROR_CODE == ERR_NONE)
      else $error("error code without alarm");
   AST_COAST_OFF: assert property ((COAST_STOP != COAST_ACTIVE_LOW) [*5] |-> !OUTPUT_ENABLE)
      else $error("output on during coast");
   AST_BOTH_RUN: assert property ((FORWARD_RUN_INPUT && REVERSE_RUN_INPUT) [*5] |-> !OUTPUT_ENABLE)
      else $error("both run inputs did not stop");
   AST_NO_RUN: assert property ((!FORWARD_RUN_INPUT && !REVERSE_RUN_INPUT) [*5] |-> !OUTPUT_ENABLE)
      else $error("output on without run");
   AST_SET_HOLD: assert property (STATE == 3'h1 && $past(STATE) == 3'h1 |-> $stable(SECOND_SET_ACTIVE))
      else $error("set changed while running");
   AST_SET_ON: assert property ((STATE == 3'h0 && SECOND_MOTOR_SELECT) [*5] |-> SECOND_SET_ACTIVE)
      else $error("second set not applied in stop");
   AST_SET_OFF: assert property ((STATE == 3'h0 && !SECOND_MOTOR_SELECT) [*5] |-> !SECOND_SET_ACTIVE)
      else $error("main set not restored in stop");
endmodule : dif_ctrl_asserts
bind dif_ctrl dif_ctrl_asserts i_dif_ctrl_asserts (.*);

// ### dif_term_model.sv
/*
 Terminal source model: switches or a controller on the input terminals.
 Assumes the bench sets requested levels; pins follow at the next edge.
*/
`timescale 1ns/1ps
module dif_term_model (
   input  wire logic       clk,
   input  wire logic [5:0] req,
   output logic      [5:0] pins
);
   initial pins = 6'h00;
   // contacts move only after a rising edge, never mid-cycle
   always @(posedge clk) pins <= req;
endmodule : dif_term_model

// ### dif_ctrl_tb_top.sv
/*
 Self-checking bench for the input-function control block.
 Assumes the terminal model drives all run, select, coast, fault and clear pins.
*/
`timescale 1ns/1ps
module dif_ctrl_tb_top;
   import dif_pkg::*;
   logic                  CLK, ARST_N, KEYPAD_RESET, COAST_ACTIVE_LOW;
   logic                  COAST_RESUME_MODE, UNATTENDED_START_GUARD;
   logic [DELAY_MS_W-1:0] RESUME_DELAY_TIME;
   logic [5:0]            term_req, pins;
   logic                  OUTPUT_ENABLE, RUN_REVERSE, START_FROM_SPEED;
   logic                  SECOND_SET_ACTIVE, ALARM, TRIP_HISTORY;
   logic [ERR_W-1:0]      ERROR_CODE;
   logic [2:0]            STATE;
   int                    mismatches = 0;
   int                    num_checks = 0;
   dif_term_model i_dif_term_model (.clk(CLK), .req(term_req), .pins(pins));
   dif_ctrl i_dif_ctrl (.CLK, .ARST_N, .FORWARD_RUN_INPUT(pins[IN_FWD]),
      .REVERSE_RUN_INPUT(pins[IN_REV]), .SECOND_MOTOR_SELECT(pins[IN_SET]),
      .COAST_STOP(pins[IN_COAST]), .EXTERNAL_FAULT(pins[IN_FAULT]),
      .FAULT_CLEAR_INPUT(pins[IN_CLEAR]), .KEYPAD_RESET, .COAST_ACTIVE_LOW,
      .COAST_RESUME_MODE, .RESUME_DELAY_TIME, .UNATTENDED_START_GUARD, .OUTPUT_ENABLE,
      .RUN_REVERSE, .START_FROM_SPEED, .SECOND_SET_ACTIVE, .ALARM, .ERROR_CODE,
      .TRIP_HISTORY, .STATE);
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   function automatic logic [7:0] st();
      return {2'h0, ALARM, OUTPUT_ENABLE, TRIP_HISTORY, STATE};
   endfunction : st
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask : cyc
   // pin takes effect one edge later, then three more inside the block;
   // returns on a falling edge so outputs are read once settled
   task automatic pin(input int idx, input logic v);
      @(posedge CLK);
      term_req[idx] <= v;
      cyc(5);
      @(negedge CLK);
   endtask : pin
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic wait_oe(input logic v, input int lim);
      int i;
      for (i = 0; i < lim && OUTPUT_ENABLE !== v; i++) @(negedge CLK);
      chk(8'(OUTPUT_ENABLE), 8'(v));
      if (i == lim) stop_test();
   endtask : wait_oe
   initial begin
      ARST_N = 1'b0;
      term_req = 6'h00;
      KEYPAD_RESET = 1'b0;
      COAST_ACTIVE_LOW = 1'b0;
      COAST_RESUME_MODE = 1'b1;
      RESUME_DELAY_TIME = 16'h0000;
      UNATTENDED_START_GUARD = 1'b1;
      cyc(6);
      ARST_N <= 1'b1;
      cyc(2);
      chk(st(), 8'h00);
      pin(IN_FWD, 1'b1);
      wait_oe(1'b1, 10);
      chk(st(), 8'h11);
      pin(IN_REV, 1'b1);
      chk(8'(OUTPUT_ENABLE), 8'h00);
      pin(IN_FWD, 1'b0);
      wait_oe(1'b1, 10);
      chk(8'(RUN_REVERSE), 8'h01);
      pin(IN_SET, 1'b1);
      chk(8'(SECOND_SET_ACTIVE), 8'h00);
      pin(IN_REV, 1'b0);
      chk(8'(SECOND_SET_ACTIVE), 8'h01);
      pin(IN_SET, 1'b0);
      chk(8'(SECOND_SET_ACTIVE), 8'h00);
      $display("test run and set done");
      pin(IN_FWD, 1'b1);
      pin(IN_COAST, 1'b1);
      chk(st(), 8'h02);
      pin(IN_COAST, 1'b0);
      wait_oe(1'b1, 10);
      chk(8'(START_FROM_SPEED), 8'h01);
      // polarity flip with the pin low makes coast active
      @(posedge CLK);
      COAST_ACTIVE_LOW <= 1'b1;
      COAST_RESUME_MODE <= 1'b0;
      RESUME_DELAY_TIME <= 16'h0001;
      cyc(6);
      chk(8'(OUTPUT_ENABLE), 8'h00);
      pin(IN_COAST, 1'b1);
      // 1 ms is 25000 cycles; look just before and just after it ends
      cyc(24989);
      @(negedge CLK);
      chk(st(), 8'h03);
      wait_oe(1'b1, 12);
      chk(8'(START_FROM_SPEED), 8'h00);
      @(posedge CLK);
      RESUME_DELAY_TIME <= 16'h0000;
      pin(IN_COAST, 1'b0);
      pin(IN_FWD, 1'b0);
      pin(IN_COAST, 1'b1);
      cyc(10);
      chk(8'(OUTPUT_ENABLE), 8'h00);
      $display("test coast done");
      pin(IN_FWD, 1'b1);
      wait_oe(1'b1, 10);
      pin(IN_FAULT, 1'b1);
      chk(st(), 8'h2c);
      chk(ERROR_CODE, ERR_EXT);
      pin(IN_FAULT, 1'b0);
      cyc(20);
      chk(st(), 8'h2c);
      pin(IN_CLEAR, 1'b1);
      chk(st(), 8'h2c);
      pin(IN_CLEAR, 1'b0);
      wait_oe(1'b1, 10);
      chk({ALARM, ERROR_CODE[6:0]}, 8'h00);
      pin(IN_FAULT, 1'b1);
      chk(8'(ALARM), 8'h01);
      pin(IN_FAULT, 1'b0);
      @(posedge CLK);
      KEYPAD_RESET <= 1'b1;
      wait_oe(1'b1, 12);
      chk(8'(ALARM), 8'h00);
      $display("test fault done");
      // latched trip, then a power cycle in mid-run clears it to stop
      pin(IN_FAULT, 1'b1);
      pin(IN_FAULT, 1'b0);
      chk(8'(ALARM), 8'h01);
      @(posedge CLK);
      ARST_N <= 1'b0;
      cyc(2);
      ARST_N <= 1'b1;
      @(negedge CLK);
      chk(st(), 8'h00);
      $display("test power cycle done");
      stop_test();
   end
endmodule : dif_ctrl_tb_top
